// [mrie_top.sv]
// master reset and interrupt enable block of the frame engine
// assumes the host bus target delivers base-decoded single-cycle register accesses
`timescale 1ns/1ps
module mrie_top (
    input  wire logic                clk_in,            // bus clock, 125 MHz
    input  wire logic                nrst_in,           // hardware reset pin, active low
    input  wire mrie_pkg::mrie_req_t req_in,            // register access, one-cycle valid
    input  wire mrie_pkg::mrie_evt_t evt_in,            // event pulses from engine
    input  wire logic [31:0]         core_tx_data_in,   // link data from the engine core
    output logic [31:0]              rdata_out,         // read data, valid cycle after access
    output logic                     rvalid_out,        // read data strobe
    output logic                     host_irq_out_n,    // interrupt to host, active low
    output logic                     core_srst_out,     // holds core logic in reset
    output logic                     standby_out,       // low-power standby request
    output logic [31:0]              tx_link_data_out   // transmit link data pins
);
    // all state of the block except the sticky status bits, which u_evt holds
    typedef struct packed {
        logic        srst;        // software reset bit
        logic [15:0] irq_en;      // interrupt enables
        logic [31:0] rdata;       // read data
        logic        rvalid;      // read strobe
        logic        irq_n;       // registered interrupt, active low
        logic [31:0] tx;          // registered link data
    } mrie_state_t;

    mrie_state_t st_ff;           // registered state
    mrie_state_t nxt_st;          // next state
    logic        acc;             // valid access with some byte enabled
    logic        wr_acc;          // write access
    logic        rd_acc;          // read access
    logic        stat_rd;         // status register read, clears it
    logic [15:0] stat;            // sticky event status
    mrie_pkg::mrie_evt_t evt_gated; // events, blocked while core in reset

    // byte enables all off means no access at all
    assign acc     = req_in.sel && (req_in.be_n != 4'hF);      // [R08] [R09]
    assign wr_acc  = acc && req_in.wr;
    assign rd_acc  = acc && !req_in.wr;
    assign stat_rd = rd_acc && (req_in.ofs == mrie_pkg::OFS_IRQ_STATUS); // [R22]

    // core is held in reset, so its events cannot arrive
    assign evt_gated.evt = st_ff.srst ? 16'h0000 : evt_in.evt; // [R10]

    // sticky status bits; soft reset returns them to defaults
    mrie_event_sync u_evt (
        .clk_in   (clk_in),
        .nrst_in  (nrst_in),
        .srst_in  (st_ff.srst),    // [R15]
        .evt_in   (evt_gated),
        .clr_in   (stat_rd),
        .stat_out (stat)
    );

    // register file, interrupt and link data next-state
    always_comb begin
        nxt_st = st_ff;
        nxt_st.rvalid = 1'b0;
        // writes update the whole word whatever byte lanes are on
        if (wr_acc) begin
            unique case (req_in.ofs)
                mrie_pkg::OFS_SOFT_RESET: begin
                    // only bit 15 stored, others ignored; stays until host writes zero or hardware reset clears it
                    nxt_st.srst = req_in.wdata[mrie_pkg::SOFT_RESET_BIT]; // [R07] [R01] [R11]
                end
                mrie_pkg::OFS_IRQ_ENABLE: begin
                    nxt_st.irq_en = req_in.wdata[15:0];                    // [R07] [R16]
                end
                default: begin
                    // status and unmapped offsets are read-only here
                    nxt_st.irq_en = st_ff.irq_en;                          // [R05]
                end
            endcase
        end
        // soft reset returns the enables to defaults
        if (st_ff.srst) begin
            nxt_st.irq_en = mrie_pkg::IRQ_ENABLE_RST;                       // [R15]
        end
        // reads return stored values, unused bits as zero
        if (rd_acc) begin
            nxt_st.rvalid = 1'b1;
            unique case (req_in.ofs)
                mrie_pkg::OFS_SOFT_RESET: begin
                    nxt_st.rdata = {16'h0000, st_ff.srst, 15'h0000};       // [R03] [R01]
                end
                mrie_pkg::OFS_IRQ_ENABLE: begin
                    nxt_st.rdata = {16'h0000, st_ff.irq_en};               // [R03]
                end
                mrie_pkg::OFS_IRQ_STATUS: begin
                    nxt_st.rdata = {16'h0000, stat};                       // [R22]
                end
                default: begin
                    nxt_st.rdata = 32'h0000_0000;
                end
            endcase
        end
        // any enabled status bit raises the interrupt; bits 0..3 are the
        // system, parity, frame check and abort sources
        nxt_st.irq_n = ~|(stat & st_ff.irq_en); // [R17] [R18] [R19] [R20] [R21] [R23]
        // link data idles high while in soft reset
        nxt_st.tx = st_ff.srst ? mrie_pkg::TX_LINK_IDLE : core_tx_data_in; // [R14]
    end

    // state register; hardware reset clears everything including reset bit
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            st_ff.srst   <= 1'b0;                        // [R13] [R04]
            st_ff.irq_en <= mrie_pkg::IRQ_ENABLE_RST;    // [R04]
            st_ff.rdata  <= 32'h0000_0000;
            st_ff.rvalid <= 1'b0;
            st_ff.irq_n  <= 1'b1;
            st_ff.tx     <= mrie_pkg::TX_LINK_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // outputs straight from flip-flops
    assign rdata_out        = st_ff.rdata;
    assign rvalid_out       = st_ff.rvalid;
    assign host_irq_out_n   = st_ff.irq_n;
    assign core_srst_out    = st_ff.srst;   // [R10]
    assign standby_out      = st_ff.srst;   // [R12]
    assign tx_link_data_out = st_ff.tx;
endmodule // mrie_top

// [mrie_pkg.sv]
// package for the master reset and interrupt enable block: offsets, fields, reset values, carriers
// assumes a register access port from the host bus target, one clock, active-low async reset
// How it works
// [R01] unused bits written are ignored
// [R02] host writes zero to unused bits
// [R03] writable bits read back last value
// [R04] writable bits clear to zero on reset
// [R05] writes to read-only bits change nothing
// [R06] host writes reserved bits with defaults only
// [R07] any write updates the whole register
// [R08] all byte enables off: no access
// [R09] offsets decoded relative to memory base
// [R10] reset bit holds core logic in reset
// [R11] reset bit not self-clearing; host clears it
// [R12] software reset means low-power standby
// [R13] hardware reset clears the reset bit
// [R14] in soft reset, link data forced high
// [R15] soft reset defaults all registers but config
// [R16] enable register: sixteen bits, default zero
// [R17] enabled events interrupt; status always records
// [R18] bit 0 enables system error events
// [R19] bit 1 enables parity error events
// [R20] bit 2 enables frame check errors
// [R21] bit 3 enables receive abort events
// [R22] status read returns and clears all bits
// [R23] interrupt while any status and enable
package mrie_pkg;
    localparam logic [10:0] OFS_SOFT_RESET  = 11'h000;  // software reset control
    localparam logic [10:0] OFS_IRQ_ENABLE  = 11'h004;  // interrupt enable mask
    localparam logic [10:0] OFS_IRQ_STATUS  = 11'h008;  // interrupt status, clear on read
    localparam int          SOFT_RESET_BIT  = 15;       // reset bit position
    localparam int          EVENT_W         = 16;       // number of event sources
    localparam int          SYS_ERR_BIT     = 0;        // system error event
    localparam int          PARITY_ERR_BIT  = 1;        // parity error event
    localparam int          FCS_ERR_BIT     = 2;        // frame check error event
    localparam int          RX_ABORT_BIT    = 3;        // receive abort event
    localparam logic [15:0] IRQ_ENABLE_RST  = 16'h0000; // enables reset value
    localparam logic [15:0] STATUS_RST      = 16'h0000; // status reset value
    localparam logic [31:0] TX_LINK_IDLE    = 32'hFFFF_FFFF; // link data in soft reset
    localparam logic [31:0] TX_LINK_RST     = 32'h0000_0000; // link data under hw reset

    // one register access from the host bus target
    typedef struct packed {
        logic        sel;       // memory space hit, already base-relative
        logic        wr;        // write when set, read otherwise
        logic [10:0] ofs;       // byte offset from base
        logic [3:0]  be_n;      // byte enables, active low
        logic [31:0] wdata;     // write data
    } mrie_req_t;

    // raw event sources, one pulse per detected event
    typedef struct packed {
        logic [15:0] evt;       // bit per status position
    } mrie_evt_t;
endpackage

// [mrie_status_bit.sv]
// one sticky status bit with clear-on-read
// assumes set and clear arrive as single-cycle pulses on clk_in
`timescale 1ns/1ps
module mrie_status_bit (
    input  wire logic clk_in,    // system clock
    input  wire logic nrst_in,   // async reset, active low
    input  wire logic srst_in,   // synchronous soft reset
    input  wire logic set_in,    // event pulse
    input  wire logic clr_in,    // read acknowledge pulse
    output logic      stat_out   // sticky status
);
    typedef struct packed {
        logic stat;              // sticky value
    } mrie_sb_t;
    mrie_sb_t st_ff;             // registered state
    mrie_sb_t nxt_st;            // next state

    // set wins over clear so no event is lost
    always_comb begin
        nxt_st = st_ff;
        if (srst_in) begin
            nxt_st.stat = 1'b0;
        end else if (set_in) begin
            nxt_st.stat = 1'b1;   // [R17]
        end else if (clr_in) begin
            nxt_st.stat = 1'b0;   // [R22]
        end
    end

    // state register
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign stat_out = st_ff.stat;
endmodule // mrie_status_bit

// [mrie_event_sync.sv]
// turns the event vector into status bits, one instance per bit
// assumes events already synchronous to clk_in
`timescale 1ns/1ps
module mrie_event_sync (
    input  wire logic              clk_in,   // system clock
    input  wire logic              nrst_in,  // async reset, active low
    input  wire logic              srst_in,  // soft reset level
    input  wire mrie_pkg::mrie_evt_t evt_in, // event pulses
    input  wire logic              clr_in,   // clear all on status read
    output logic [15:0]            stat_out  // sticky status vector
);
    // one sticky bit per event source
    for (genvar i = 0; i < mrie_pkg::EVENT_W; i++) begin : g_bit
        mrie_status_bit u_bit (
            .clk_in   (clk_in),
            .nrst_in  (nrst_in),
            .srst_in  (srst_in),
            .set_in   (evt_in.evt[i]),
            .clr_in   (clr_in),
            .stat_out (stat_out[i])
        );
    end
endmodule // mrie_event_sync

// [mrie_properties.sv]
// checker for the reset and interrupt enable block
// assumes it is bound to mrie_top, one clock, async active-low reset
`timescale 1ns/1ps
module mrie_properties (
    input wire logic                clk_in,
    input wire logic                nrst_in,
    input wire mrie_pkg::mrie_req_t req_in,
    input wire mrie_pkg::mrie_evt_t evt_in,
    input wire logic [31:0]         rdata_out,
    input wire logic                rvalid_out,
    input wire logic                host_irq_out_n,
    input wire logic                core_srst_out,
    input wire logic                standby_out,
    input wire logic [31:0]         tx_link_data_out
);
    logic tk, rd, wr0, rd8;  // taken access, taken read, reset write, status read
    assign tk  = req_in.sel && req_in.be_n != 4'hF;
    assign rd  = tk && !req_in.wr;
    assign wr0 = tk && req_in.wr && req_in.ofs == mrie_pkg::OFS_SOFT_RESET;
    assign rd8 = rd && req_in.ofs == mrie_pkg::OFS_IRQ_STATUS;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    // status read with no fresh event around it
    sequence s_ack;
        (rd8 && evt_in.evt == 16'h0000) ##1 (evt_in.evt == 16'h0000);
    endsequence
    // soft reset held long enough to settle
    sequence s_held;
        core_srst_out [*3];
    endsequence
    a_read_gets_strobe: assert property (rd |=> rvalid_out)
        else $error("read without strobe");
    a_no_stray_strobe: assert property (!rd |=> !rvalid_out)
        else $error("strobe without read");
    a_srst_written: assert property (wr0 |=> core_srst_out == $past(req_in.wdata[15]))
        else $error("reset bit not written");
    a_srst_sticks: assert property (core_srst_out && !wr0 |=> core_srst_out)
        else $error("reset bit cleared itself");
    a_srst_stays_off: assert property (!core_srst_out && !wr0 |=> !core_srst_out)
        else $error("reset bit set without write");
    a_standby_tracks: assert property (standby_out == core_srst_out)
        else $error("standby differs from reset");
    a_link_forced_high: assert property (s_held |-> tx_link_data_out == mrie_pkg::TX_LINK_IDLE)
        else $error("link data not high");
    a_irq_quiet_srst: assert property (s_held |-> host_irq_out_n)
        else $error("interrupt during soft reset");
    a_read_clears_irq: assert property (s_ack |=> host_irq_out_n)
        else $error("interrupt left after status read");
    a_hw_clears_srst: assert property ($rose(nrst_in) |-> !core_srst_out)
        else $error("reset bit survived hardware reset");
    a_unused_zero: assert property (rd && req_in.ofs == 11'h000 |=> rdata_out[14:0] == 15'h0000)
        else $error("unused bits not zero");
endmodule // mrie_properties
bind mrie_top mrie_properties u_mrie_properties (.clk_in(clk_in), .nrst_in(nrst_in), .req_in(req_in),
    .evt_in(evt_in), .rdata_out(rdata_out), .rvalid_out(rvalid_out), .host_irq_out_n(host_irq_out_n),
    .core_srst_out(core_srst_out), .standby_out(standby_out), .tx_link_data_out(tx_link_data_out));

// [mrie_host.sv]
// host bus model issuing single-cycle register accesses
// assumes the block samples requests on the rising edge of clk_in
`timescale 1ns/1ps
module mrie_host (
    input  wire logic           clk_in,  // bus clock
    output mrie_pkg::mrie_req_t req_out  // request toward the block
);
    // drive after a falling edge, hold across one rising edge, then release
    task automatic acc(input logic w, input logic [10:0] o, input logic [3:0] be, input logic [31:0] d);
        @(negedge clk_in);
        req_out = '{sel: 1'b1, wr: w, ofs: o, be_n: be, wdata: d & 32'h0000FFFF};
        @(negedge clk_in);
        req_out = mrie_pkg::mrie_req_t'(~req_out);  // released lines stop showing old value, sel drops to zero
    endtask
    initial req_out = '0;
endmodule // mrie_host

// [mrie_top_tb.sv]
// self-checking bench for the reset and interrupt enable block
// assumes mrie_host drives the request port
`timescale 1ns/1ps
module mrie_top_tb;
    logic clk_in, nrst_in, rv, irq_n, srst, stby;
    logic [31:0] core_tx, rdata, tx, e;
    mrie_pkg::mrie_req_t req;
    mrie_pkg::mrie_evt_t evt;
    int mismatches, n_tests;
    logic [31:0] expq[$];  // expected read data, oldest first
    mrie_host u_mrie_host (.clk_in(clk_in), .req_out(req));
    mrie_top u_mrie_top (.clk_in(clk_in), .nrst_in(nrst_in), .req_in(req), .evt_in(evt),
        .core_tx_data_in(core_tx), .rdata_out(rdata), .rvalid_out(rv), .host_irq_out_n(irq_n),
        .core_srst_out(srst), .standby_out(stby), .tx_link_data_out(tx));
    initial begin
        clk_in = 1'b0;
        forever #4 clk_in = ~clk_in;
    end
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
        n_tests++;
        if (s !== x) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, x, s);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic rd(input logic [10:0] o, input logic [31:0] x);
        expq.push_back(x);
        u_mrie_host.acc(1'b0, o, 4'h0, 32'h0);
    endtask
    task automatic ev(input int b);
        @(negedge clk_in) evt.evt = 16'h0001 << b;
        @(negedge clk_in) evt.evt = 16'h0000;
    endtask
    // read results taken from the queue as they appear
    always @(negedge clk_in) begin
        if (rv === 1'b1) begin
            if (expq.size() == 0) chk("rvalid", 32'h1, 32'h0);
            else chk("rdata", rdata, expq.pop_front());
        end
    end
    initial begin
        #100000;
        mismatches++;
        summarize();
    end
    initial begin
        nrst_in = 1'b0;
        evt = '0;
        core_tx = $urandom(42537);
        repeat (16) @(negedge clk_in);
        nrst_in = 1'b1;
        rd(mrie_pkg::OFS_SOFT_RESET, 32'h0);
        rd(mrie_pkg::OFS_IRQ_ENABLE, 32'h0);
        e = $urandom & 32'hFFFF;
        u_mrie_host.acc(1'b1, mrie_pkg::OFS_IRQ_ENABLE, 4'hE, e);
        u_mrie_host.acc(1'b1, mrie_pkg::OFS_IRQ_ENABLE, 4'hF, 32'h0);
        rd(mrie_pkg::OFS_IRQ_ENABLE, e);
        rd(11'h7FC, 32'h0);
        u_mrie_host.acc(1'b1, mrie_pkg::OFS_IRQ_STATUS, 4'h0, 32'hFFFF);
        rd(mrie_pkg::OFS_IRQ_ENABLE, e);
        rd(mrie_pkg::OFS_IRQ_STATUS, 32'h0);
        $display("registers done");
        for (int b = 0; b < 16; b++) begin
            u_mrie_host.acc(1'b1, mrie_pkg::OFS_IRQ_ENABLE, 4'h0, 32'h1 << b);
            ev(b);
            @(negedge clk_in);
            chk("irq", irq_n, 32'h0);
            u_mrie_host.acc(1'b0, mrie_pkg::OFS_IRQ_STATUS, 4'hF, 32'h0);
            rd(mrie_pkg::OFS_IRQ_STATUS, 32'h1 << b);
            repeat (2) @(negedge clk_in);
            chk("irq", irq_n, 32'h1);
            ev((b + 1) % 16);
            repeat (2) @(negedge clk_in);
            chk("irq", irq_n, 32'h1);
            rd(mrie_pkg::OFS_IRQ_STATUS, 32'h1 << ((b + 1) % 16));
        end
        $display("events done");
        u_mrie_host.acc(1'b1, mrie_pkg::OFS_SOFT_RESET, 4'h0, 32'h8000);
        repeat (3) @(negedge clk_in);
        chk("srst", srst, 32'h1);
        chk("standby", stby, 32'h1);
        chk("tx", tx, 32'hFFFFFFFF);
        rd(mrie_pkg::OFS_SOFT_RESET, 32'h8000);
        rd(mrie_pkg::OFS_IRQ_ENABLE, 32'h0);
        ev(0);
        rd(mrie_pkg::OFS_IRQ_STATUS, 32'h0);
        u_mrie_host.acc(1'b1, mrie_pkg::OFS_SOFT_RESET, 4'h0, 32'h0);
        repeat (2) @(negedge clk_in);
        chk("srst", srst, 32'h0);
        chk("tx", tx, core_tx);
        u_mrie_host.acc(1'b1, mrie_pkg::OFS_SOFT_RESET, 4'h0, 32'h8000);
        chk("srst", srst, 32'h1);
        nrst_in = 1'b0;
        @(negedge clk_in) nrst_in = 1'b1;
        chk("srst", srst, 32'h0);
        rd(mrie_pkg::OFS_SOFT_RESET, 32'h0);
        repeat (2) @(negedge clk_in);
        chk("pending", expq.size(), 32'h0);
        $display("reset done");
        summarize();
    end
endmodule // mrie_top_tb
